//--- verilog/dcmp_defs.svh
// Register offsets, field positions and reset values for the dual comparator control block
`ifndef DCMP_DEFS_SVH
`define DCMP_DEFS_SVH
// ----------------------------------------------------------------------
// Register byte addresses (one 32-bit word each)
// ----------------------------------------------------------------------
`define DCMP_A_CTRL_ADDR 12'h000
`define DCMP_A_MODE_ADDR 12'h004
`define DCMP_B_CTRL_ADDR 12'h008
`define DCMP_B_MODE_ADDR 12'h00C
`define DCMP_IRQ_ADDR 12'h010
// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define DCMP_CTL_EN 7
`define DCMP_CTL_OUT 6
`define DCMP_CTL_RIF 5
`define DCMP_CTL_FIF 4
`define DCMP_CTL_HYP_HI 3
`define DCMP_CTL_HYP_LO 2
`define DCMP_CTL_HYN_HI 1
`define DCMP_CTL_HYN_LO 0
`define DCMP_CTL_PMUX_LO 8
`define DCMP_CTL_NMUX_LO 16
// ----------------------------------------------------------------------
// Mode register fields and reset values
// ----------------------------------------------------------------------
`define DCMP_MD_RSV 7
`define DCMP_MD_RIE 5
`define DCMP_MD_FIE 4
`define DCMP_MD_MD_HI 1
`define DCMP_MD_MD_LO 0
`define DCMP_MD_RESET 2'h2
`define DCMP_HYS_RESET 2'h0
// ----------------------------------------------------------------------
// Interrupt routing register fields
// ----------------------------------------------------------------------
`define DCMP_IRQ_GIE 0
`define DCMP_IRQ_SRC_A 1
`define DCMP_IRQ_SRC_B 2
`endif

//--- verilog/dcmp_pkg.sv
// Types shared by the dual comparator control block
package dcmp_pkg;
    // Per-comparator software state
    typedef struct packed {
        logic en;
        logic sync1;
        logic sync2;
        logic rise_flag;
        logic fall_flag;
        logic [1:0] pos_hyst;
        logic [1:0] neg_hyst;
        logic rise_ie;
        logic fall_ie;
        logic [1:0] mode;
        logic src_en;
    } dcmp_chan_t;
    // Bus access phases
    typedef enum logic [1:0] {
        DCMP_IDLE = 2'b01,
        DCMP_ACC  = 2'b10
    } dcmp_phase_t;
endpackage

//--- verilog/dcmp_top.sv
// Dual comparator digital control with APB register access
//
// Contract
// - Enabled output follows compare, else zero
// - Clock-synchronized copy of each output
// - Synced output readable, interrupt source, pin
// - Raw output feeds wake and reset logic
// - Raw pin output valid without clock
// - Detect both rising and falling edges
// - Flags set regardless of interrupt enable
// - Flags cleared only by software write
// - Per-edge enables in mode register
// - Irq needs flag, enable, source, global
// - Four response-time modes selectable
// - Disabled comparator enters low-power shutdown
// - No compare until enable set
// - Independent positive/negative hysteresis selects
// - Hysteresis delays respective output transitions
// - Input mux selects set by software
// - Both comparators share identical logic
// - Mode 00 fastest, 11 lowest power
// - Hysteresis 00 off, 11 maximum
// - Mode reserved bit reads one
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "dcmp_defs.svh"
module dcmp_top import dcmp_pkg::*; #(
    parameter int MUX_W = 4
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Analog comparator results
    input wire logic CMP_A_ANALOG,
    input wire logic CMP_B_ANALOG,
    // Raw outputs to wake, reset and pin logic
    output logic CMP_A_RAW_OUT,
    output logic CMP_B_RAW_OUT,
    // Latched outputs to pin crossbar
    output logic CMP_A_LATCHED_OUT,
    output logic CMP_B_LATCHED_OUT,
    // Analog control
    output logic [1:0] CMP_ENABLE,
    output logic [3:0] CMP_MODE,
    output logic [3:0] CMP_POS_HYST_SEL,
    output logic [3:0] CMP_NEG_HYST_SEL,
    output logic [2*MUX_W-1:0] CMP_POS_MUX,
    output logic [2*MUX_W-1:0] CMP_NEG_MUX,
    // Interrupt request
    output logic CMP_IRQ
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        dcmp_chan_t [1:0] ch;
        logic [1:0][MUX_W-1:0] pmux;
        logic [1:0][MUX_W-1:0] nmux;
        logic gie;
        dcmp_phase_t phase;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic irq;
        logic [1:0] seen; // Synced output one cycle late, for edges
    } dcmp_state_t;

    dcmp_state_t st;
    dcmp_state_t next_st;
    logic [1:0] analog;
    logic [1:0] raw;

    // Mux selects live in the upper bytes of the control word
    localparam int PMUX_LO = `DCMP_CTL_PMUX_LO;
    localparam int NMUX_LO = `DCMP_CTL_NMUX_LO;

    // Register index decode, used by both read and write paths
    function automatic logic [2:0] dcmp_decode(input logic [11:0] a);
        unique case (a)
            `DCMP_A_CTRL_ADDR: dcmp_decode = 3'h0;
            `DCMP_A_MODE_ADDR: dcmp_decode = 3'h1;
            `DCMP_B_CTRL_ADDR: dcmp_decode = 3'h2;
            `DCMP_B_MODE_ADDR: dcmp_decode = 3'h3;
            `DCMP_IRQ_ADDR: dcmp_decode = 3'h4;
            default: dcmp_decode = 3'h7;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Raw path
    // ------------------------------------------------------------------
    assign analog = {CMP_B_ANALOG, CMP_A_ANALOG};
    // no synchronizer in path; combinational so valid with clock stopped
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_raw
            assign raw[gi] = analog[gi] & st.ch[gi].en;
        end
    endgenerate
    assign CMP_A_RAW_OUT = raw[0];
    assign CMP_B_RAW_OUT = raw[1];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [2:0] idx;
        logic [31:0] rd;
        logic wr;
        idx = dcmp_decode(PADDR);
        rd = 32'h0;
        wr = 1'b0;
        next_st = st;
        next_st.ready = 1'b0;
        next_st.err = 1'b0;
        for (int i = 0; i < 2; i++) begin
            next_st.ch[i].sync1 = raw[i];
            next_st.ch[i].sync2 = st.ch[i].sync1;
            // Delayed copy of the synced output, compared for edges below
            next_st.seen[i] = st.ch[i].sync2;
        end
        // APB access phase, answered in the second access cycle, after one wait state
        unique case (st.phase)
            DCMP_IDLE: begin
                if (PSEL && !PENABLE) begin
                    next_st.phase = DCMP_ACC;
                end
            end
            DCMP_ACC: begin
                next_st.phase = DCMP_IDLE;
                next_st.ready = 1'b1;
                next_st.err = (idx == 3'h7);
                wr = PSEL & PENABLE & PWRITE;
                for (int i = 0; i < 2; i++) begin
                    if (idx == 3'(2 * i)) begin
                        rd[`DCMP_CTL_EN] = st.ch[i].en;
                        rd[`DCMP_CTL_OUT] = st.ch[i].sync2;
                        rd[`DCMP_CTL_RIF] = st.ch[i].rise_flag;
                        rd[`DCMP_CTL_FIF] = st.ch[i].fall_flag;
                        rd[`DCMP_CTL_HYP_HI:`DCMP_CTL_HYP_LO] = st.ch[i].pos_hyst;
                        rd[`DCMP_CTL_HYN_HI:`DCMP_CTL_HYN_LO] = st.ch[i].neg_hyst;
                        rd[PMUX_LO +: MUX_W] = st.pmux[i];
                        rd[NMUX_LO +: MUX_W] = st.nmux[i];
                        if (wr) begin
                            next_st.ch[i].en = PWDATA[`DCMP_CTL_EN];
                            // writing 0 clears a flag, writing 1 keeps it
                            next_st.ch[i].rise_flag = st.ch[i].rise_flag & PWDATA[`DCMP_CTL_RIF];
                            next_st.ch[i].fall_flag = st.ch[i].fall_flag & PWDATA[`DCMP_CTL_FIF];
                            next_st.ch[i].pos_hyst = PWDATA[`DCMP_CTL_HYP_HI:`DCMP_CTL_HYP_LO];
                            next_st.ch[i].neg_hyst = PWDATA[`DCMP_CTL_HYN_HI:`DCMP_CTL_HYN_LO];
                            next_st.pmux[i] = PWDATA[PMUX_LO +: MUX_W];
                            next_st.nmux[i] = PWDATA[NMUX_LO +: MUX_W];
                        end
                    end
                    if (idx == 3'(2 * i + 1)) begin
                        rd[`DCMP_MD_RSV] = 1'b1;
                        rd[`DCMP_MD_RIE] = st.ch[i].rise_ie;
                        rd[`DCMP_MD_FIE] = st.ch[i].fall_ie;
                        rd[`DCMP_MD_MD_HI:`DCMP_MD_MD_LO] = st.ch[i].mode;
                        if (wr) begin
                            next_st.ch[i].rise_ie = PWDATA[`DCMP_MD_RIE];
                            next_st.ch[i].fall_ie = PWDATA[`DCMP_MD_FIE];
                            next_st.ch[i].mode = PWDATA[`DCMP_MD_MD_HI:`DCMP_MD_MD_LO];
                        end
                    end
                end
                if (idx == 3'h4) begin
                    rd[`DCMP_IRQ_GIE] = st.gie;
                    rd[`DCMP_IRQ_SRC_A] = st.ch[0].src_en;
                    rd[`DCMP_IRQ_SRC_B] = st.ch[1].src_en;
                    if (wr) begin
                        next_st.gie = PWDATA[`DCMP_IRQ_GIE];
                        next_st.ch[0].src_en = PWDATA[`DCMP_IRQ_SRC_A];
                        next_st.ch[1].src_en = PWDATA[`DCMP_IRQ_SRC_B];
                    end
                end
                next_st.rdata = rd;
            end
            default: next_st.phase = DCMP_IDLE;
        endcase
        // both edges of the synced output are caught
        // flag rises one cycle after the synced change
        // set whatever the enables; set beats a same-cycle clear
        for (int i = 0; i < 2; i++) begin
            if (st.ch[i].sync2 & ~st.seen[i]) begin
                next_st.ch[i].rise_flag = 1'b1;
            end
            if (~st.ch[i].sync2 & st.seen[i]) begin
                next_st.ch[i].fall_flag = 1'b1;
            end
        end
        next_st.irq = 1'b0;
        for (int i = 0; i < 2; i++) begin
            next_st.irq = next_st.irq | (st.gie & st.ch[i].src_en &
                ((st.ch[i].rise_flag & st.ch[i].rise_ie) | (st.ch[i].fall_flag & st.ch[i].fall_ie)));
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            st <= '0;
            st.phase <= DCMP_IDLE;
            st.ch[0].mode <= `DCMP_MD_RESET;
            st.ch[1].mode <= `DCMP_MD_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // latched outputs to crossbar; en low shuts analog down
    assign CMP_A_LATCHED_OUT = st.ch[0].sync2;
    assign CMP_B_LATCHED_OUT = st.ch[1].sync2;
    assign CMP_ENABLE = {st.ch[1].en, st.ch[0].en};
    assign CMP_MODE = {st.ch[1].mode, st.ch[0].mode};
    assign CMP_POS_HYST_SEL = {st.ch[1].pos_hyst, st.ch[0].pos_hyst};
    assign CMP_NEG_HYST_SEL = {st.ch[1].neg_hyst, st.ch[0].neg_hyst};
    // hysteresis applied by analog core using selects
    assign CMP_POS_MUX = {st.pmux[1], st.pmux[0]};
    assign CMP_NEG_MUX = {st.nmux[1], st.nmux[0]};
    assign PRDATA = st.rdata;
    assign PREADY = st.ready;
    assign PSLVERR = st.err;
    assign CMP_IRQ = st.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_raw_gate;
        @(posedge MCLK) disable iff (!NRST) !st.ch[0].en |-> !CMP_A_RAW_OUT;
    endproperty
    a_raw_gate: assert property (p_raw_gate) else $error("raw out high while disabled");
    property p_rise_set;
        @(posedge MCLK) disable iff (!NRST) (st.ch[0].sync2 & !st.seen[0]) |=> st.ch[0].rise_flag;
    endproperty
    a_rise_set: assert property (p_rise_set) else $error("rise flag not set");
    property p_fall_set;
        @(posedge MCLK) disable iff (!NRST) (!st.ch[1].sync2 & st.seen[1]) |=> st.ch[1].fall_flag;
    endproperty
    a_fall_set: assert property (p_fall_set) else $error("fall flag not set");
    property p_sticky;
        @(posedge MCLK) disable iff (!NRST) (st.ch[0].rise_flag & !(PSEL & PENABLE & PWRITE)) |=> st.ch[0].rise_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag cleared without write");
    property p_irq;
        @(posedge MCLK) disable iff (!NRST) !st.gie |=> !CMP_IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without global enable");
    property p_ready;
        @(posedge MCLK) disable iff (!NRST) (PSEL & !PENABLE & st.phase == DCMP_IDLE) |=> ##1 PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after access");
    property p_sync;
        @(posedge MCLK) disable iff (!NRST) $rose(st.ch[0].sync1) |=> CMP_A_LATCHED_OUT;
    endproperty
    a_sync: assert property (p_sync) else $error("sync stage stuck");
    property p_mode_rst;
        @(posedge MCLK) $rose(NRST) |-> CMP_MODE == {2{`DCMP_MD_RESET}};
    endproperty
    a_mode_rst: assert property (p_mode_rst) else $error("mode reset value");
    property p_sticky_b;
        @(posedge MCLK) disable iff (!NRST) (st.ch[1].fall_flag & !(PSEL & PENABLE & PWRITE)) |=> st.ch[1].fall_flag;
    endproperty
    a_sticky_b: assert property (p_sticky_b) else $error("fall flag cleared without write");
    property p_irq_src;
        @(posedge MCLK) disable iff (!NRST) (!st.ch[0].src_en & !st.ch[1].src_en) |=> !CMP_IRQ;
    endproperty
    a_irq_src: assert property (p_irq_src) else $error("irq without any source");
    property p_dis_latched;
        @(posedge MCLK) disable iff (!NRST) (!st.ch[1].en ##1 !st.ch[1].en ##1 !st.ch[1].en) |-> !CMP_B_LATCHED_OUT;
    endproperty
    a_dis_latched: assert property (p_dis_latched) else $error("latched out high while disabled");
    c_rise: cover property (@(posedge MCLK) st.ch[0].rise_flag);
    c_fall: cover property (@(posedge MCLK) st.ch[1].fall_flag);
    c_irq: cover property (@(posedge MCLK) CMP_IRQ);
    c_err: cover property (@(posedge MCLK) PSLVERR);
endmodule // dcmp_top

//--- bench/dcmp_analog_model.sv
// Behavioural model of the analog comparator front ends and their response delay
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Analog model
// ----------------------------------------------------------------------
module dcmp_analog_model (
    // Clock
    input wire logic mclk,
    // Bench-requested compare result, per channel
    input wire logic [1:0] target,
    // Response-time settings from the block, 2 bits per channel
    input wire logic [3:0] mode,
    // Compare results seen by the block
    output logic [1:0] analog
);
    logic [1:0] cnt [2];
    initial begin
        analog = 2'h0;
        cnt[0] = 2'h0;
        cnt[1] = 2'h0;
    end
    // slower modes respond later
    // Mode 0 answers in one cycle, mode 3 in four; the tests move the inputs only in the reset mode 2, three cycles
    always @(posedge mclk) begin
        for (int ch = 0; ch < 2; ch++) begin
            if (analog[ch] == target[ch]) begin
                cnt[ch] <= 2'h0;
            end else if (cnt[ch] >= mode[2*ch +: 2]) begin
                analog[ch] <= target[ch];
                cnt[ch] <= 2'h0;
            end else begin
                cnt[ch] <= cnt[ch] + 2'h1;
            end
        end
    end
endmodule // dcmp_analog_model

//--- bench/test_dual_comparator_digital_control.sv
// Self-checking register-level testbench for the dual comparator control block
`timescale 1ns/100ps
`include "dcmp_defs.svh"
module test_dual_comparator_digital_control import dcmp_pkg::*;;
    // ------------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------------
    logic mclk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, irq;
    logic [1:0] target = 2'h0, analog, raw, latched, en;
    logic [3:0] mode, hp, hn;
    logic [7:0] pmux, nmux;
    int failures = 0, cmp_count = 0, cyc = 0;
    always #25 mclk = ~mclk;
    dcmp_top dut (.MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CMP_A_ANALOG(analog[0]), .CMP_B_ANALOG(analog[1]), .CMP_A_RAW_OUT(raw[0]),
        .CMP_B_RAW_OUT(raw[1]), .CMP_A_LATCHED_OUT(latched[0]), .CMP_B_LATCHED_OUT(latched[1]),
        .CMP_ENABLE(en), .CMP_MODE(mode), .CMP_POS_HYST_SEL(hp), .CMP_NEG_HYST_SEL(hn),
        .CMP_POS_MUX(pmux), .CMP_NEG_MUX(nmux), .CMP_IRQ(irq));
    dcmp_analog_model model (.mclk(mclk), .target(target), .mode(mode), .analog(analog));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is sampled high, a hang is left to the run timeout
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string msg);
        apb(1'h0, a, 32'h0);
        chk(rd, exp, msg);
    endtask
    // Bounded wait for the latched output, then two more cycles for the edge flag
    task automatic settle(input int ch, input logic v);
        int n;
        n = 0;
        while (latched[ch] !== v && n < 20) begin
            @(posedge mclk);
            n++;
        end
        repeat (2) @(posedge mclk);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            $display("unexpected at %0t: run timed out", $time);
            results();
        end
    end
    // ------------------------------------------------------------------
    // Main sequence, both channels through identical steps
    // ------------------------------------------------------------------
    initial begin
        logic [11:0] b;
        repeat (2) @(posedge mclk);
        nrst <= 1'h1;
        for (int ch = 0; ch < 2; ch++) begin
            b = 12'(ch * 8);
            rdchk(b + 12'h004, 32'h82, "mode reset");
            rdchk(b, 32'h0, "ctrl reset");
            target[ch] <= 1'h1;
            repeat (8) @(posedge mclk);
            chk({31'h0, raw[ch]}, 32'h0, "raw while disabled");
            chk({31'h0, latched[ch]}, 32'h0, "latched while disabled");
            apb(1'h1, b, 32'h80);
            settle(ch, 1'h1);
            chk({31'h0, raw[ch]}, 32'h1, "raw enabled");
            chk({31'h0, latched[ch]}, 32'h1, "latched enabled");
            rdchk(b, 32'hE0, "rise flag");
            apb(1'h1, b, 32'h80);
            rdchk(b, 32'hC0, "rise cleared");
            target[ch] <= 1'h0;
            settle(ch, 1'h0);
            repeat (10) @(posedge mclk);
            rdchk(b, 32'h90, "fall flag kept");
            chk({31'h0, irq}, 32'h0, "irq no enable");
            apb(1'h1, b + 12'h004, 32'h90);
            chk({31'h0, irq}, 32'h0, "irq no source");
            apb(1'h1, `DCMP_IRQ_ADDR, 32'h1 | (32'h2 << ch));
            @(posedge mclk);
            chk({31'h0, irq}, 32'h1, "irq raised");
            apb(1'h1, `DCMP_IRQ_ADDR, 32'h1);
            @(posedge mclk);
            chk({31'h0, irq}, 32'h0, "irq source off");
            apb(1'h1, `DCMP_IRQ_ADDR, 32'h2 << ch);
            @(posedge mclk);
            chk({31'h0, irq}, 32'h0, "irq global off");
            apb(1'h1, `DCMP_IRQ_ADDR, 32'h7);
            apb(1'h1, b + 12'h004, 32'h80);
            @(posedge mclk);
            chk({31'h0, irq}, 32'h0, "irq edge enable off");
            apb(1'h1, `DCMP_IRQ_ADDR, 32'h0);
            for (int m = 0; m < 4; m++) begin
                apb(1'h1, b + 12'h004, 32'h80 | 32'(m));
                chk({30'h0, mode[2*ch +: 2]}, 32'(m), "mode pins");
                rdchk(b + 12'h004, 32'h80 | 32'(m), "mode readback");
            end
            apb(1'h1, b, 32'h000A058B);
            chk({30'h0, hp[2*ch +: 2]}, 32'h2, "pos hyst");
            chk({30'h0, hn[2*ch +: 2]}, 32'h3, "neg hyst");
            chk({28'h0, pmux[4*ch +: 4]}, 32'h5, "pos mux");
            chk({28'h0, nmux[4*ch +: 4]}, 32'hA, "neg mux");
            apb(1'h1, b, 32'h0);
            @(posedge mclk);
            chk({31'h0, en[ch]}, 32'h0, "disabled");
            $display("channel %0d test done", ch);
        end
        apb(1'h0, 12'h014, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        $display("unmapped access test done");
        results();
    end
endmodule // test_dual_comparator_digital_control
